// file: src/adc_seq_pkg.sv
// shared constants, state codes and carriers of the conversion sequencer
package adc_seq_pkg;

	// ====================================================================
	// widths
	localparam int RESULT_W = 12;
	localparam int HALF_CNT_W = 6;
	localparam int AGE_W = 2;
	localparam int CAL_CNT_W = 22;

	// ====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETUP_NS = 10;
	// least time: round up, never below one cycle
	localparam int SETUP_CYCLES_RAW = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYCLES = (SETUP_CYCLES_RAW < 1) ? 1 : SETUP_CYCLES_RAW;
	// conversion length in master-clock half periods (16.5 and 17.5 periods)
	localparam logic [HALF_CNT_W-1:0] HALVES_NORMAL = 6'h21;
	localparam logic [HALF_CNT_W-1:0] HALVES_LATE = 6'h23;
	localparam int CAL_TIMEOUT_MS = 70;
	localparam int CAL_CYCLES = CAL_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

	// ====================================================================
	// states
	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_edge = 4'h2,
		st_conv = 4'h4,
		st_cal = 4'h8
	} seq_state_e;

	// ====================================================================
	// carriers
	typedef struct packed {
		logic convert_start_n;
		logic master_clock_in;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic start_bit;
	} pins_s;

	localparam pins_s PINS_IDLE = '{
		convert_start_n: 1'b1, master_clock_in: 1'b0, cs_n: 1'b1,
		rd_n: 1'b1, wr_n: 1'b1, start_bit: 1'b0};

	typedef struct packed {
		seq_state_e state;
		logic [HALF_CNT_W-1:0] half_cnt;
		logic [HALF_CNT_W-1:0] target;
		logic [AGE_W-1:0] age;
		logic [CAL_CNT_W-1:0] cal_cnt;
		logic mclk_prev;
		logic cnv_prev;
		logic wr_prev;
		logic start_bit_lat;
		logic sw_start;
		logic cal_pending;
		logic busy;
		logic hold;
		logic data_oe;
		logic cal_run;
		logic [RESULT_W-1:0] result;
	} seq_s;

	localparam seq_s SEQ_RESET = '{
		state: st_idle, half_cnt: '0, target: '0, age: '0, cal_cnt: '0,
		mclk_prev: 1'b0, cnv_prev: 1'b1, wr_prev: 1'b0, start_bit_lat: 1'b0,
		sw_start: 1'b0, cal_pending: 1'b1, busy: 1'b0, hold: 1'b0,
		data_oe: 1'b0, cal_run: 1'b0, result: '0};

endpackage : adc_seq_pkg

// file: src/pin_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_s;

	sync_s r;
	sync_s nxt;

	// ====================================================================
	// meta stage feeds only the stable stage
	always_comb begin
		nxt.meta = d;
		nxt.stable = r.meta;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '{meta: RESET_VALUE, stable: RESET_VALUE};
		end else begin
			r <= nxt;
		end
	end

	assign q = r.stable;
endmodule : pin_sync

// file: src/adc_conversion_sequencer.sv
// conversion sequencer: start detection, timing, busy, track/hold and result bus
//
// Contract
// - pin low strobe or software bit starts conversion
// - hold at pin rise or write end
// - begin at next master fall, 16.5 periods
// - late start edge gives 17.5 periods
// - busy low at completion, result readable
// - software start bit cleared at busy fall
// - first start after power-up runs calibration
// - result driven while read and select low
// - back to tracking at busy fall
// - straight binary unipolar, twos complement bipolar
// - control write before first start skips calibration
`timescale 1ns/10ps
module adc_conversion_sequencer #(
	parameter logic [adc_seq_pkg::CAL_CNT_W-1:0] CAL_CYCLES =
		adc_seq_pkg::CAL_CNT_W'(adc_seq_pkg::CAL_CYCLES)
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic convert_start_n,
	input wire logic master_clock_in,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic start_bit_in,
	input wire logic bipolar_mode,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] sar_code,
	output logic busy,
	output logic track_hold,
	output logic [adc_seq_pkg::RESULT_W-1:0] data_out,
	output logic data_oe,
	output logic sw_start_bit,
	output logic cal_running
);

	// ====================================================================
	// output coding
	// the core delivers offset binary; bipolar flips the sign bit
	function automatic logic [adc_seq_pkg::RESULT_W-1:0] code_fmt(
		input logic [adc_seq_pkg::RESULT_W-1:0] raw,
		input logic bip
	);
		logic [adc_seq_pkg::RESULT_W-1:0] v;
		v = raw;
		if (bip) begin
			v[adc_seq_pkg::RESULT_W-1] = ~raw[adc_seq_pkg::RESULT_W-1];
		end
		return v;
	endfunction : code_fmt

	// ====================================================================
	// pin synchronisers
	adc_seq_pkg::pins_s pins_raw;
	adc_seq_pkg::pins_s p;

	assign pins_raw = '{convert_start_n: convert_start_n, master_clock_in: master_clock_in,
		cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, start_bit: start_bit_in};

	pin_sync #(
		.W($bits(adc_seq_pkg::pins_s)),
		.RESET_VALUE(adc_seq_pkg::PINS_IDLE)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.d(pins_raw),
		.q(p)
	);

	// ====================================================================
	// sequencer state
	adc_seq_pkg::seq_s r;
	adc_seq_pkg::seq_s nxt;

	logic mclk_fall;
	logic mclk_edge;
	logic pin_rise;
	logic wr_act;
	logic wr_end;
	logic sw_launch;
	logic trig;
	logic cal_go;
	logic done;
	logic [adc_seq_pkg::HALF_CNT_W-1:0] half_inc;

	always_comb begin
		nxt = r;
		mclk_fall = r.mclk_prev & ~p.master_clock_in;
		mclk_edge = r.mclk_prev ^ p.master_clock_in;
		pin_rise = ~r.cnv_prev & p.convert_start_n;
		wr_act = ~p.cs_n & ~p.wr_n;
		wr_end = r.wr_prev & ~wr_act;
		// start takes effect when the write ends, not when it begins
		sw_launch = wr_end & r.start_bit_lat;
		trig = pin_rise | sw_launch;
		// a write that ends before or with the first start cancels calibration
		cal_go = r.cal_pending & ~wr_end;
		done = 1'b0;
		half_inc = r.half_cnt + 6'h01;

		nxt.mclk_prev = p.master_clock_in;
		nxt.cnv_prev = p.convert_start_n;
		nxt.wr_prev = wr_act;
		if (wr_act) begin
			nxt.start_bit_lat = p.start_bit;
		end
		if (wr_end) begin
			nxt.cal_pending = 1'b0;
		end
		nxt.data_oe = ~p.cs_n & ~p.rd_n;

		unique case (r.state)
			adc_seq_pkg::st_idle: begin
				if (trig) begin
					nxt.busy = 1'b1;
					nxt.hold = 1'b1;
					nxt.cal_pending = 1'b0;
					// readback only for a software start that really launched
					nxt.sw_start = sw_launch;
					if (cal_go) begin
						nxt.state = adc_seq_pkg::st_cal;
						nxt.cal_cnt = '0;
						nxt.cal_run = 1'b1;
					end else if (mclk_fall) begin
						// fall in the start cycle itself misses setup
						nxt.state = adc_seq_pkg::st_conv;
						nxt.half_cnt = '0;
						nxt.target = adc_seq_pkg::HALVES_LATE;
					end else begin
						nxt.state = adc_seq_pkg::st_edge;
						nxt.age = 2'h1;
					end
				end
			end
			adc_seq_pkg::st_edge: begin
				if (r.age != 2'h3) begin
					nxt.age = r.age + 2'h1;
				end
				if (mclk_fall) begin
					nxt.state = adc_seq_pkg::st_conv;
					nxt.half_cnt = '0;
					if (32'(r.age) < adc_seq_pkg::SETUP_CYCLES) begin
						nxt.target = adc_seq_pkg::HALVES_LATE;
					end else begin
						nxt.target = adc_seq_pkg::HALVES_NORMAL;
					end
				end
			end
			adc_seq_pkg::st_conv: begin
				if (mclk_edge) begin
					nxt.half_cnt = half_inc;
					if (half_inc == r.target) begin
						done = 1'b1;
						nxt.result = code_fmt(sar_code, bipolar_mode);
					end
				end
			end
			adc_seq_pkg::st_cal: begin
				// calibration keeps busy high; the result register is untouched
				nxt.cal_cnt = r.cal_cnt + 22'h000001;
				if (nxt.cal_cnt >= CAL_CYCLES) begin
					done = 1'b1;
					nxt.cal_run = 1'b0;
				end
			end
		endcase

		if (done) begin
			nxt.state = adc_seq_pkg::st_idle;
			nxt.busy = 1'b0;
			nxt.hold = 1'b0;
			// a write ending with the fall launches nothing, so the bit must not linger
			nxt.sw_start = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= adc_seq_pkg::SEQ_RESET;
		end else begin
			r <= nxt;
		end
	end

	// ====================================================================
	// outputs
	assign busy = r.busy;
	assign track_hold = r.hold;
	assign data_out = r.result;
	assign data_oe = r.data_oe;
	assign sw_start_bit = r.sw_start;
	assign cal_running = r.cal_run;

endmodule : adc_conversion_sequencer

// file: sim/adc_seq_monitor.sv
// checker of the sequencer port behaviour
`timescale 1ns/10ps
module adc_seq_monitor #(
	parameter logic [adc_seq_pkg::CAL_CNT_W-1:0] CAL_CYCLES = 22'h000014
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic convert_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic busy,
	input wire logic track_hold,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] data_out,
	input wire logic data_oe,
	input wire logic sw_start_bit,
	input wire logic cal_running
);
	// ==========
	// assertions
	localparam int CAL_LO = CAL_CYCLES - 1;
	localparam int CAL_HI = CAL_CYCLES + 1;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_pin_starts: assert property ($rose(convert_start_n) && !busy |-> ##[1:4] busy)
		else $error("no busy after start pin rise");
	a_hold_on_start: assert property ($rose(busy) |-> track_hold || cal_running)
		else $error("sample not held at start");
	a_track_at_fall: assert property ($fell(busy) |-> !track_hold)
		else $error("not tracking after busy fall");
	a_bit_cleared: assert property ($fell(busy) |-> !sw_start_bit)
		else $error("start bit not cleared");
	a_result_held: assert property ($changed(data_out) |-> $fell(busy))
		else $error("result changed outside completion");
	a_oe_on_read: assert property ((!cs_n && !rd_n) [*4] |-> data_oe)
		else $error("data not driven during read");
	a_oe_off: assert property (cs_n [*4] |-> !data_oe)
		else $error("data driven without select");
	a_hold_in_busy: assert property (track_hold |-> busy)
		else $error("hold outside conversion");
	a_cal_busy: assert property (cal_running |-> busy)
		else $error("calibration without busy");
	a_cal_length: assert property ($rose(cal_running) |-> ##[CAL_LO:CAL_HI] $fell(cal_running))
		else $error("calibration length wrong");
	c_cal: cover property ($fell(cal_running));
	c_read: cover property ($rose(data_oe));
	c_sw: cover property ($fell(sw_start_bit));
endmodule : adc_seq_monitor

bind adc_conversion_sequencer adc_seq_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon_u (
	.clock(clock), .sys_rst(sys_rst), .convert_start_n(convert_start_n), .cs_n(cs_n),
	.rd_n(rd_n), .busy(busy), .track_hold(track_hold), .data_out(data_out),
	.data_oe(data_oe), .sw_start_bit(sw_start_bit), .cal_running(cal_running));

// file: sim/host_model.sv
// host side model: start pin, strobes and master clock source
`timescale 1ns/10ps
module host_model (
	input wire logic clock,
	output logic convert_start_n,
	output logic master_clock_in,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic start_bit_in
);
	// ==========
	// pin drivers
	initial begin
		{convert_start_n, cs_n, rd_n, wr_n, start_bit_in, master_clock_in} = 6'h3d;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	// late start puts the master fall at the start rise
	task automatic start_strobe(input logic late);
		convert_start_n = 1'b0;
		step(2);
		convert_start_n = 1'b1;
		if (late) master_clock_in = 1'b0;
	endtask : start_strobe
	task automatic write_open(input logic bit_v);
		{cs_n, wr_n} = 2'h0;
		start_bit_in = bit_v;
	endtask : write_open
	task automatic write_close();
		{cs_n, wr_n} = 2'h3;
		start_bit_in = ~start_bit_in; // released line shows no stale value
		step(1);
	endtask : write_close
	// strobes only between conversions
	task automatic write(input logic bit_v);
		write_open(bit_v);
		step(4);
		write_close();
	endtask : write
	task automatic rd(input logic active);
		{cs_n, rd_n} = active ? 2'h0 : 2'h3;
	endtask : rd
	// slow master clock, one edge per call
	task automatic tick();
		master_clock_in = ~master_clock_in;
		step(5);
	endtask : tick
endmodule : host_model

// file: sim/test_adc_conversion_sequencer.sv
// testbench of the conversion sequencer
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
	logic clock;
	logic sys_rst;
	logic bipolar_mode;
	logic [11:0] sar_code;
	logic convert_start_n, master_clock_in, cs_n, rd_n, wr_n, start_bit_in;
	logic busy, track_hold, data_oe, sw_start_bit, cal_running;
	logic [11:0] data_out;
	int failures = 0;
	int n_compared = 0;
	always #25 clock = ~clock;
	host_model host_u (.clock(clock), .convert_start_n(convert_start_n),
		.master_clock_in(master_clock_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.start_bit_in(start_bit_in));
	adc_conversion_sequencer #(.CAL_CYCLES(22'h000014)) dut_u (.clock(clock),
		.sys_rst(sys_rst), .convert_start_n(convert_start_n),
		.master_clock_in(master_clock_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.start_bit_in(start_bit_in), .bipolar_mode(bipolar_mode), .sar_code(sar_code),
		.busy(busy), .track_hold(track_hold), .data_out(data_out), .data_oe(data_oe),
		.sw_start_bit(sw_start_bit), .cal_running(cal_running));
	// ==========
	// tasks
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic wait_idle(input int lim);
		int k;
		for (k = 0; k < lim && busy !== 1'b0; k++) host_u.step(1);
		if (busy !== 1'b0) begin
			failures++;
			complete_run();
		end
	endtask : wait_idle
	task automatic calibrate();
		host_u.start_strobe(1'b0);
		host_u.step(4);
		check(cal_running, 1'b1);
		wait_idle(40);
		check(data_out, 12'h000);
		host_u.step(10);
	endtask : calibrate
	task automatic convert(input logic sw, input logic late, input logic bip,
		input logic [11:0] code, input int edges);
		int n;
		bipolar_mode = bip;
		sar_code = code;
		if (sw) host_u.write(1'b1);
		else host_u.start_strobe(late);
		if (late) host_u.step(5);
		else begin
			host_u.step(4);
			host_u.tick();
		end
		check(busy, 1'b1);
		check(track_hold, 1'b1);
		check(cal_running, 1'b0);
		check(sw_start_bit, sw);
		for (n = 1; n < 40 && busy === 1'b1; n++) host_u.tick();
		wait_idle(1);
		check(12'(n - 1), 12'(edges));
		check(track_hold, 1'b0);
		check(sw_start_bit, 1'b0);
		host_u.rd(1'b1);
		host_u.step(5);
		check(data_oe, 1'b1);
		check(data_out, bip ? code ^ 12'h800 : code);
		host_u.rd(1'b0);
		host_u.step(10); // acquisition gap before the next start
	endtask : convert
	// software restart at full rate: write held across the busy fall
	task automatic back_to_back();
		int n;
		host_u.start_strobe(1'b0);
		host_u.step(4);
		host_u.tick();
		host_u.write_open(1'b1);
		for (n = 1; n < 40 && busy === 1'b1; n++) host_u.tick();
		check(12'(n - 1), 12'h021);
		check(sw_start_bit, 1'b0);
		host_u.step(15); // acquisition of 1.5 master periods
		check(busy, 1'b0);
		host_u.write_close();
		host_u.step(4);
		host_u.tick();
		check(busy, 1'b1);
		check(track_hold, 1'b1);
		check(sw_start_bit, 1'b1);
		for (n = 1; n < 40 && busy === 1'b1; n++) host_u.tick();
		wait_idle(1);
		check(12'(n - 1), 12'h021);
		check(sw_start_bit, 1'b0);
		host_u.step(10);
	endtask : back_to_back
	// ==========
	// main sequence
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		bipolar_mode = 1'b0;
		sar_code = 12'h000;
		host_u.step(3);
		sys_rst = 1'b0;
		host_u.step(1);
		calibrate();
		convert(1'b0, 1'b0, 1'b0, 12'h5a3, 33);
		convert(1'b0, 1'b1, 1'b1, 12'h0f1, 35);
		convert(1'b1, 1'b0, 1'b1, 12'hfff, 33);
		back_to_back();
		sys_rst = 1'b1;
		host_u.step(3);
		sys_rst = 1'b0;
		host_u.step(1);
		host_u.write(1'b0);
		convert(1'b0, 1'b0, 1'b0, 12'h801, 33);
		complete_run();
	end
endmodule : test_adc_conversion_sequencer
